//--- rtl/pkgt_gpio.sv
/*
  Port K and port T general-purpose I/O with alternative-function precedence
  on port T, reached by software over APB.
  Assumes pin inputs are synchronous to clock, and that the timer, routed PWM
  and regulator periodic-interrupt sources present their enables and levels
  as plain synchronous inputs.
  Assumes an APB master that holds each request until pready; the answer comes
  in the first access cycle while clk_en stays high; clk_en low at the setup edge leaves it unanswered.
  Pin outputs are registered, so they follow their sources one clock later.
  Reset acts at any edge, whether clk_en is high or not.
*/
`timescale 1ns/1ps
`include "pkgt_regs.svh"

////////////////////////////////////////////////////////////////////////////////

module pkgt_gpio #(
  parameter int PADDR_W = 16
) (
  input wire logic clock, // 100 MHz bus clock
  input wire logic reset, // synchronous, active high
  input wire logic clk_en, // low freezes all state
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [PADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  output logic [31:0] prdata, // APB read data
  input wire pkgt_pkg::pkgt_alt_s alt, // timer, PWM, regulator sources
  input wire logic [7:0] port_t_in, // port T pin levels
  output logic [7:0] port_t_out, // port T pin drive values
  output logic [7:0] port_t_oe_n, // port T enables, low drives
  input wire logic [7:0] port_k_in, // port K pin levels
  output logic [7:0] port_k_out, // port K pin drive values
  output logic [7:0] port_k_oe_n // port K enables, low drives
);

  ////////////////////////////////////////////////////////////////////////////////

  // Elaboration checks: refuse settings that the decode and pin logic cannot serve.
  if (PADDR_W < 10 || PADDR_W > 32) begin : g_bad_addr_width
    $error("pkgt_gpio: PADDR_W must lie between 10 and 32");
  end
  if (`PKGT_APB_WAIT_CYCLES != 0) begin : g_bad_wait
    $error("pkgt_gpio: the answer logic serves zero wait states only");
  end
  if (`PKGT_T_PWM_LSB + 4 != 8) begin : g_bad_pwm_lsb
    $error("pkgt_gpio: routed PWM must cover the top four port T bits");
  end
  if (`PKGT_T_API_BIT < `PKGT_T_PWM_LSB || `PKGT_T_API_BIT > 7) begin : g_bad_api_bit
    $error("pkgt_gpio: the regulator output bit must lie among the PWM bits");
  end

  localparam logic [7:0] K_MASK = `PKGT_K_IMPL_MASK;

  pkgt_pkg::pkgt_state_s s_q;
  pkgt_pkg::pkgt_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////////

  // Address decode, shared by the read path and the write path.
  // Unaligned and unmapped addresses both fall to the default and answer with an error.
  function automatic pkgt_pkg::pkgt_sel_e decode(input logic [31:0] a);
    pkgt_pkg::pkgt_sel_e r;
    r = pkgt_pkg::PKGT_SEL_NONE;
    case (a)
      `PKGT_OFS_PORT_T_DATA: begin
        r = pkgt_pkg::PKGT_SEL_T_DATA;
      end
      `PKGT_OFS_PORT_T_DIRECTION: begin
        r = pkgt_pkg::PKGT_SEL_T_DIR;
      end
      `PKGT_OFS_PORT_K_DATA: begin
        r = pkgt_pkg::PKGT_SEL_K_DATA;
      end
      `PKGT_OFS_PORT_K_DIRECTION: begin
        r = pkgt_pkg::PKGT_SEL_K_DIR;
      end
      default: begin
        r = pkgt_pkg::PKGT_SEL_NONE;
      end
    endcase
    return r;
  endfunction

  // Data readback: stored bit where the pin is an output, pin level otherwise.
  // Forced alternative outputs still read by the stored direction bit.
  function automatic logic [7:0] readback(
    input logic [7:0] data,
    input logic [7:0] dir,
    input logic [7:0] pin
  );
    return (data & dir) | (pin & ~dir);
  endfunction

  // Write merge: only the low byte lane stores, and only implemented bits take
  // the data, so an unimplemented bit keeps reading zero.
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] wdata,
    input logic [7:0] impl,
    input logic lane
  );
    return lane ? (wdata & impl) : old;
  endfunction

  // Read word of one register: the low byte carries the value, the rest is zero.
  function automatic logic [31:0] read_word(
    input pkgt_pkg::pkgt_sel_e which,
    input pkgt_pkg::pkgt_state_s regs,
    input logic [7:0] t_pin,
    input logic [7:0] k_pin
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (which)
      pkgt_pkg::PKGT_SEL_T_DATA: begin
        w[7:0] = readback(regs.port_t_data, regs.port_t_direction, t_pin);
      end
      pkgt_pkg::PKGT_SEL_T_DIR: begin
        w[7:0] = regs.port_t_direction;
      end
      pkgt_pkg::PKGT_SEL_K_DATA: begin
        w[7:0] = readback(regs.port_k_data, regs.port_k_direction, k_pin) & K_MASK;
      end
      pkgt_pkg::PKGT_SEL_K_DIR: begin
        w[7:0] = regs.port_k_direction & K_MASK;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  // Port T pin precedence, one copy per bit.
  // Each branch lists the sources from strongest to weakest.
  logic [7:0] t_drive;
  logic [7:0] t_value;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_port_t
      if (gi >= `PKGT_T_PWM_LSB && gi != `PKGT_T_API_BIT) begin : g_tpwm
        always_comb begin
          if (alt.tim_en[gi]) begin
            t_drive[gi] = 1'b1;
            t_value[gi] = alt.tim_val[gi];
          end else if (alt.pwm_en[gi-`PKGT_T_PWM_LSB]) begin
            t_drive[gi] = 1'b1;
            t_value[gi] = alt.pwm_val[gi-`PKGT_T_PWM_LSB];
          end else begin
            t_drive[gi] = s_q.port_t_direction[gi];
            t_value[gi] = s_q.port_t_data[gi];
          end
        end
      end else if (gi == `PKGT_T_API_BIT) begin : g_tapi
        always_comb begin
          if (alt.tim_en[gi]) begin
            t_drive[gi] = 1'b1;
            t_value[gi] = alt.tim_val[gi];
          end else if (alt.pwm_en[gi-`PKGT_T_PWM_LSB]) begin
            t_drive[gi] = 1'b1;
            t_value[gi] = alt.pwm_val[gi-`PKGT_T_PWM_LSB];
          end else if (alt.api_en) begin
            t_drive[gi] = 1'b1;
            t_value[gi] = alt.api_val;
          end else begin
            t_drive[gi] = s_q.port_t_direction[gi];
            t_value[gi] = s_q.port_t_data[gi];
          end
        end
      end else begin : g_tlow
        always_comb begin
          if (alt.tim_en[gi]) begin
            t_drive[gi] = 1'b1;
            t_value[gi] = alt.tim_val[gi];
          end else begin
            t_drive[gi] = s_q.port_t_direction[gi];
            t_value[gi] = s_q.port_t_data[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////

  // Port K pin drive, one copy per bit; the missing bit is held released.
  logic [7:0] k_drive;
  logic [7:0] k_value;

  generate
    for (gi = 0; gi < 8; gi++) begin : g_port_k
      if (K_MASK[gi]) begin : g_kimpl
        always_comb begin
          k_drive[gi] = s_q.port_k_direction[gi];
          k_value[gi] = s_q.port_k_data[gi];
        end
      end else begin : g_kgap
        // No pin logic behind this bit: released, and its value held low.
        always_comb begin
          k_drive[gi] = 1'b0;
          k_value[gi] = 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////

  logic [31:0] addr_ext;
  pkgt_pkg::pkgt_sel_e sel;
  logic wr_lane;

  assign addr_ext = 32'(paddr);
  assign sel = decode(addr_ext);
  assign wr_lane = pstrb[0];

  always_comb begin
    s_d = s_q;

    // Direction bits steer the pins; alternative functions only override the
    // pin, so forced outputs leave the stored direction untouched.
    s_d.t_pins.oe_n = ~t_drive;
    s_d.t_pins.value = t_value;

    s_d.k_pins.oe_n = ~k_drive;
    s_d.k_pins.value = k_value;

    // The read word and the error flag are taken at the setup edge; the write
    // lands at the access edge, where pready is already high.
    case (s_q.st)
      pkgt_pkg::PKGT_ST_IDLE: begin
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && !penable) begin
          // Answer is prepared at the setup edge so pready can be a flop.
          s_d.st = pkgt_pkg::PKGT_ST_ANSWER;
          s_d.pready = 1'b1;
          s_d.prdata = read_word(sel, s_q, port_t_in, port_k_in);
          if (sel == pkgt_pkg::PKGT_SEL_NONE) begin
            s_d.pslverr = 1'b1;
          end
        end
      end

      pkgt_pkg::PKGT_ST_ANSWER: begin
        if (psel && penable) begin
          s_d.st = pkgt_pkg::PKGT_ST_IDLE;
          s_d.pready = 1'b0;
          s_d.pslverr = 1'b0;
          if (pwrite) begin
            case (sel)
              pkgt_pkg::PKGT_SEL_T_DATA: begin
                s_d.port_t_data = merge(s_q.port_t_data, pwdata[7:0], 8'hff, wr_lane);
              end
              pkgt_pkg::PKGT_SEL_T_DIR: begin
                s_d.port_t_direction = merge(s_q.port_t_direction, pwdata[7:0],
                  8'hff, wr_lane);
              end
              pkgt_pkg::PKGT_SEL_K_DATA: begin
                s_d.port_k_data = merge(s_q.port_k_data, pwdata[7:0],
                  K_MASK, wr_lane);
              end
              pkgt_pkg::PKGT_SEL_K_DIR: begin
                s_d.port_k_direction = merge(s_q.port_k_direction, pwdata[7:0],
                  K_MASK, wr_lane);
              end
              default: begin
                s_d.port_t_data = s_q.port_t_data;
              end
            endcase
          end
        end else begin
          // Master dropped the transfer: abandon the answer.
          s_d.st = pkgt_pkg::PKGT_ST_IDLE;
          s_d.pready = 1'b0;
          s_d.pslverr = 1'b0;
        end
      end

      default: begin
        s_d.st = pkgt_pkg::PKGT_ST_IDLE;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Reset is not gated by clk_en, so a frozen block can still be brought back
  // to a known state.
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q.st <= pkgt_pkg::PKGT_ST_IDLE;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
      s_q.port_t_data <= `PKGT_RST_PORT_T_DATA;
      s_q.port_t_direction <= `PKGT_RST_PORT_T_DIRECTION;
      s_q.port_k_data <= `PKGT_RST_PORT_K_DATA;
      s_q.port_k_direction <= `PKGT_RST_PORT_K_DIRECTION;
      s_q.t_pins.value <= 8'h00;
      s_q.t_pins.oe_n <= 8'hff;
      s_q.k_pins.value <= 8'h00;
      s_q.k_pins.oe_n <= 8'hff;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign prdata = s_q.prdata;
  assign port_t_out = s_q.t_pins.value;
  assign port_t_oe_n = s_q.t_pins.oe_n;
  assign port_k_out = s_q.k_pins.value;
  assign port_k_oe_n = s_q.k_pins.oe_n;

endmodule

//--- rtl/pkgt_pkg.sv
/*
  Types shared by the port K / port T general-purpose I/O block.
  Assumes the constants of pkgt_regs.svh; holds types only.
*/
package pkgt_pkg;

  typedef enum logic [1:0] {
    PKGT_ST_IDLE = 2'b01,
    PKGT_ST_ANSWER = 2'b10
  } pkgt_apb_e;

  typedef enum logic [4:0] {
    PKGT_SEL_NONE = 5'h01,
    PKGT_SEL_T_DATA = 5'h02,
    PKGT_SEL_T_DIR = 5'h04,
    PKGT_SEL_K_DATA = 5'h08,
    PKGT_SEL_K_DIR = 5'h10
  } pkgt_sel_e;

  // Alternative functions that may take port T pins over.
  typedef struct packed {
    logic [7:0] tim_en;
    logic [7:0] tim_val;
    logic [3:0] pwm_en;
    logic [3:0] pwm_val;
    logic api_en;
    logic api_val;
  } pkgt_alt_s;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] oe_n;
  } pkgt_pin_s;

  typedef struct packed {
    pkgt_apb_e st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] port_t_data;
    logic [7:0] port_t_direction;
    logic [7:0] port_k_data;
    logic [7:0] port_k_direction;
    pkgt_pin_s t_pins;
    pkgt_pin_s k_pins;
  } pkgt_state_s;

endpackage

//--- rtl/pkgt_regs.svh
/*
  Register map, field masks, reset values and bus answer timing of the
  port K / port T general-purpose I/O block.
  Assumes a 32-bit APB with byte addresses; each register takes one aligned word.
*/
`ifndef PKGT_REGS_SVH
`define PKGT_REGS_SVH

`define PKGT_OFS_PORT_T_DATA 32'h0000_0240
`define PKGT_OFS_PORT_T_DIRECTION 32'h0000_0244
`define PKGT_OFS_PORT_K_DATA 32'h0000_0248
`define PKGT_OFS_PORT_K_DIRECTION 32'h0000_024c

`define PKGT_RST_PORT_T_DATA 8'h00
`define PKGT_RST_PORT_T_DIRECTION 8'h00
`define PKGT_RST_PORT_K_DATA 8'h00
`define PKGT_RST_PORT_K_DIRECTION 8'h00

`define PKGT_K_IMPL_MASK 8'hbf
`define PKGT_T_PWM_LSB 4
`define PKGT_T_API_BIT 5

`define PKGT_APB_WAIT_CYCLES 0

`endif

//--- verif/pkgt_gpio_asserts.sv
/* Concurrent checks on the port pins and APB answer of pkgt_gpio.
   Assumes one clock domain, zero wait states and pins lagging sources by one clock. */
`timescale 1ns/1ps
module pkgt_gpio_asserts (
  input wire logic clock, // clock
  input wire logic reset, // sync reset
  input wire logic clk_en, // clock enable
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [31:0] prdata, // read data
  input wire pkgt_pkg::pkgt_alt_s alt, // alt sources
  input wire logic [7:0] port_t_out, // T drive
  input wire logic [7:0] port_t_oe_n, // T enables
  input wire logic [7:0] port_k_out, // K drive
  input wire logic [7:0] port_k_oe_n // K enables
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
////////////////////////////////////////
  chk_k_bit_six: assert property (
    port_k_oe_n[6] && !port_k_out[6]) else $error("port k bit 6 driven");
  chk_reset_idle: assert property (disable iff (1'b0)
    reset |=> port_t_oe_n == 8'hff && port_k_oe_n == 8'hff && !pready)
    else $error("pins not idle after reset");
  chk_ready_pulse: assert property (pready && clk_en |=> !pready) else $error("ready held");
  chk_ready_cause: assert property (
    $rose(pready) |-> $past(psel && !penable)) else $error("ready without setup");
  chk_err_ready: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  chk_rdata_high: assert property (
    pready |-> prdata[31:8] == 24'h0) else $error("read data high bits set");
  for (genvar b = 0; b < 8; b++) begin : g_tim
    chk_tim_wins: assert property (clk_en && alt.tim_en[b] |=>
      !port_t_oe_n[b] && port_t_out[b] == $past(alt.tim_val[b])) else $error("timer lost pin");
  end
  for (genvar i = 0; i < 4; i++) begin : g_pwm
    chk_pwm_wins: assert property (clk_en && !alt.tim_en[i+4] && alt.pwm_en[i] |=>
      !port_t_oe_n[i+4] && port_t_out[i+4] == $past(alt.pwm_val[i])) else $error("pwm lost pin");
  end
  chk_api_wins: assert property (
    clk_en && !alt.tim_en[5] && !alt.pwm_en[1] && alt.api_en |=>
    !port_t_oe_n[5] && port_t_out[5] == $past(alt.api_val)) else $error("regulator lost pin");
  chk_freeze_pins: assert property (
    !clk_en |=> $stable(port_t_out) && $stable(port_t_oe_n) && $stable(port_k_out) &&
    $stable(port_k_oe_n) && $stable(prdata) && !pready) else $error("state moved while frozen");
endmodule

//--- verif/pkgt_pin_model.sv
/* External pin model for both ports.
   Assumes a released pin follows the level the outside device puts on it. */
`timescale 1ns/1ps
module pkgt_pin_model (
  input wire logic [7:0] t_out, // T drive
  input wire logic [7:0] t_oe_n, // T enables
  input wire logic [7:0] k_out, // K drive
  input wire logic [7:0] k_oe_n, // K enables
  input wire logic [7:0] t_ext, // outside level T
  input wire logic [7:0] k_ext, // outside level K
  output logic [7:0] t_in, // T wire level
  output logic [7:0] k_in // K wire level
);
  // Masking keeps an undefined drive value off a released wire.
  assign t_in = (t_out & ~t_oe_n) | (t_ext & t_oe_n);
  assign k_in = (k_out & ~k_oe_n) | (k_ext & k_oe_n);
endmodule

//--- verif/tb_top.sv
/* Self-checking bench for pkgt_gpio with a register and pin model.
   Assumes the header offsets and zero-wait APB of the design. */
`timescale 1ns/1ps
`include "pkgt_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic clock = 0, reset = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] pstrb = 0;
  logic pready, pslverr;
  pkgt_pkg::pkgt_alt_s alt = '0;
  logic [7:0] t_in, t_out, t_oe_n, k_in, k_out, k_oe_n, t_ext = 0, k_ext = 0;
  logic [7:0] m [4], xo [2], xe [2];
  int mismatches = 0, total_checks = 0;
  always #5 clock = ~clock;
  pkgt_gpio uut (.clock(clock), .reset(reset), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .alt(alt), .port_t_in(t_in),
    .port_t_out(t_out), .port_t_oe_n(t_oe_n), .port_k_in(k_in), .port_k_out(k_out),
    .port_k_oe_n(k_oe_n));
  pkgt_pin_model pins (.t_out(t_out), .t_oe_n(t_oe_n), .k_out(k_out), .k_oe_n(k_oe_n),
    .t_ext(t_ext), .k_ext(k_ext), .t_in(t_in), .k_in(k_in));
////////////////////////////////////////
  task automatic calc();
    xe[1] = ~(m[3] & 8'hbf);
    xo[1] = m[2] & m[3];
    for (int b = 0; b < 8; b++) begin
      {xe[0][b], xo[0][b]} = {~m[1][b], m[0][b]};
      if (b == 5 && alt.api_en) {xe[0][b], xo[0][b]} = {1'b0, alt.api_val};
      if (b > 3 && alt.pwm_en[b%4]) {xe[0][b], xo[0][b]} = {1'b0, alt.pwm_val[b%4]};
      if (alt.tim_en[b]) {xe[0][b], xo[0][b]} = {1'b0, alt.tim_val[b]};
    end
  endtask
  function automatic logic [7:0] exp_rd(input int i);
    logic [7:0] pt, pk;
    pt = (xo[0] & ~xe[0]) | (t_ext & xe[0]);
    pk = (xo[1] & ~xe[1]) | (k_ext & xe[1]);
    case (i)
      0: return (m[0] & m[1]) | (pt & ~m[1]);
      2: return ((m[2] & m[3]) | (pk & ~m[3])) & 8'hbf;
      1, 3: return m[i];
      default: return 8'h00;
    endcase
  endfunction
  // Must be entered just after a rising edge; the request is left standing.
  task automatic apb(input int i, input logic w, input logic [7:0] d);
    int n;
    logic [3:0] s;
    s = 4'($urandom);
    calc();
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= 16'(`PKGT_OFS_PORT_T_DATA + 4 * i);
    pwdata <= {24'($urandom), d};
    pstrb <= s;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1)
    `CHK(pslverr, 1'(i == 4))
    if (!w) `CHK(prdata, 32'(exp_rd(i)))
    else if (i < 4 && s[0]) m[i] = d & (i > 1 ? 8'hbf : 8'hff);
  endtask
  task automatic op(input int i, input logic w, input logic [7:0] d);
    apb(i, w, d);
    // Only reads are chained, so pin lag never meets a fresh write.
    if (!w && $urandom_range(1)) apb($urandom_range(4), 0, 8'h00);
    psel <= 0;
    penable <= 0;
    repeat (3) @(posedge clock);
    calc();
    `CHK(t_oe_n, xe[0])
    `CHK(t_out & ~xe[0], xo[0] & ~xe[0])
    `CHK(k_oe_n, xe[1])
    `CHK(k_out & ~xe[1], xo[1] & ~xe[1])
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    conclude();
  end
  initial begin
    void'($urandom(83));
    m = '{default: 8'h00};
    repeat (20) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    for (int i = 0; i < 5; i++) op(i, 0, 8'h00);
    op(1, 1, 8'hff);
    op(0, 0, 8'h00);
    repeat (400) begin
      alt <= pkgt_pkg::pkgt_alt_s'(26'($urandom));
      t_ext <= 8'($urandom);
      k_ext <= 8'($urandom);
      repeat (2) @(posedge clock);
      op($urandom_range(4), 1'($urandom), 8'($urandom));
      if ($urandom_range(3) == 0) begin
        // Frozen clock enable: new sources must not reach the pins.
        clk_en <= 0;
        alt <= pkgt_pkg::pkgt_alt_s'(26'($urandom));
        repeat (3) @(posedge clock);
        `CHK(t_oe_n, xe[0])
        `CHK(t_out & ~xe[0], xo[0] & ~xe[0])
        `CHK(k_oe_n, xe[1])
        clk_en <= 1;
      end
    end
    // Mid-run reset: every register and pin returns to its reset value.
    reset <= 1;
    alt <= '0;
    repeat (2) @(posedge clock);
    reset <= 0;
    m = '{default: 8'h00};
    @(posedge clock);
    for (int i = 0; i < 4; i++) op(i, 0, 8'h00);
    conclude();
  end
endmodule
bind pkgt_gpio pkgt_gpio_asserts chk (.clock(clock), .reset(reset), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .alt(alt), .port_t_out(port_t_out), .port_t_oe_n(port_t_oe_n),
  .port_k_out(port_k_out), .port_k_oe_n(port_k_oe_n));
